// ==== hw/pps_top.sv ====
// port power control and configuration strap capture for downstream ports 3 and 4
// assumes decoded SMBus byte accesses and OTP load writes on the same clock
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
(
  // clock and power-on reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // external chip reset pin, asynchronous
  input  wire logic        i_ext_reset_b,
  // port 3 shared power enable / strap pin
  input  wire logic        i_port3_power_enable,
  output logic             o_port3_power_enable,
  output logic             o_port3_power_enable_oe,
  input  wire logic        i_port3_overcurrent_sense_b,
  // port 4 shared power enable / strap pin
  input  wire logic        i_port4_power_enable,
  output logic             o_port4_power_enable,
  output logic             o_port4_power_enable_oe,
  input  wire logic        i_port4_overcurrent_sense_b,
  // supply detect and fixed port straps
  input  wire logic        i_local_supply_detect,
  input  wire logic [1:0]  i_fixed_port_straps,
  // hub core requests and status
  input  wire logic [1:0]  i_port_power_request,
  output logic      [1:0]  o_port_charge_enable,
  output logic      [1:0]  o_port_overcurrent,
  output logic      [1:0]  o_port_fixed,
  output logic             o_self_powered,
  output logic             o_dynamic_power_active,
  output logic             o_config_done,
  // SMBus register access
  input  wire logic        i_smb_wr,
  input  wire logic        i_smb_rd,
  input  wire logic [15:0] i_smb_addr,
  input  wire logic [7:0]  i_smb_wdata,
  output logic      [7:0]  o_smb_rdata,
  output logic             o_smb_rvalid,
  // OTP load writes
  input  wire logic        i_otp_wr,
  input  wire logic [15:0] i_otp_addr,
  input  wire logic [7:0]  i_otp_wdata
);

  localparam logic [SYN_WIDTH-1:0] SYN_RESET = 8'h31;  // idle levels: reset pin, sense lines high
  localparam logic [9:0]           CFG_LAST  = 10'(CONFIG_CYCLES - 1);

  pps_state_t       state;
  pps_state_t       next_state;
  logic [9:0]       cfg_count;
  logic             cfg_end;
  logic [SYN_WIDTH-1:0] syn_in;
  logic [SYN_WIDTH-1:0] syn;
  logic             ext_reset_prev;
  logic             ext_rise;

  logic [7:0]       dynamic_power_switch_cfg;
  logic [7:0]       port_mode_cfg;
  logic             wr_en;
  logic [15:0]      wr_addr;
  logic [7:0]       wr_data;
  logic             dynamic_on;
  logic             local_use;

  logic [1:0]       charge_strap;
  logic [1:0]       fixed_strap;
  logic             supply_capture;
  logic             run;
  logic [1:0]       power_on;
  logic [1:0]       overcurrent;
  logic [7:0]       status;

  // all pin inputs cross into the clock domain through one filter bank
  always_comb begin
    syn_in                              = '0;
    syn_in[SYN_EXT_RESET]               = i_ext_reset_b;
    syn_in[SYN_LOCAL]                   = i_local_supply_detect;
    syn_in[SYN_PIN3]                    = i_port3_power_enable;
    syn_in[SYN_PIN4]                    = i_port4_power_enable;
    syn_in[SYN_SENSE3]                  = i_port3_overcurrent_sense_b;
    syn_in[SYN_SENSE4]                  = i_port4_overcurrent_sense_b;
    syn_in[SYN_FIXED_LSB+1:SYN_FIXED_LSB] = i_fixed_port_straps;
  end

  pps_sync3 #(
    .WIDTH     (SYN_WIDTH),
    .RESET_VAL (SYN_RESET)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (syn_in),
    .o_sync  (syn)
  );

  // external reset edge detect; starts at the idle level so no false edge follows reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ext_reset_prev <= 1'b1;
    end else begin
      ext_reset_prev <= syn[SYN_EXT_RESET];
    end
  end

  assign ext_rise = syn[SYN_EXT_RESET] && !ext_reset_prev;

  // sequencing: standby while the pin is low, configuration window on release
  always_comb begin
    next_state = state;
    unique case (state)
      PPS_STANDBY: begin
        if (ext_rise) begin
          next_state = PPS_CONFIG;
        end
      end
      PPS_CONFIG: begin
        if (!syn[SYN_EXT_RESET] && ext_reset_prev) begin
          next_state = PPS_STANDBY;
        end else if (cfg_end) begin
          next_state = PPS_RUN;
        end
      end
      PPS_RUN: begin
        if (!syn[SYN_EXT_RESET] && ext_reset_prev) begin
          next_state = PPS_STANDBY;
        end
      end
    endcase
  end

  // power-on reset enters configuration directly so straps are taken at POR
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state <= PPS_CONFIG;
    end else begin
      state <= next_state;
    end
  end

  // configuration window length; pins are released for its whole span
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || state != PPS_CONFIG) begin
      cfg_count <= 10'h000;
    end else if (!cfg_end) begin
      cfg_count <= cfg_count + 10'h001;
    end
  end

  assign cfg_end = (state == PPS_CONFIG) && (cfg_count == CFG_LAST);
  assign run     = (state == PPS_RUN);

  // strap capture at the end of the window, after the filter has settled
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      charge_strap   <= 2'b00;
      fixed_strap    <= 2'b00;
      supply_capture <= 1'b0;
    end else if (cfg_end) begin
      charge_strap   <= {syn[SYN_PIN4], syn[SYN_PIN3]};
      fixed_strap    <= syn[SYN_FIXED_LSB+1:SYN_FIXED_LSB];
      supply_capture <= syn[SYN_LOCAL];
    end
  end

  // SMBus wins a same-cycle clash with an OTP load write
  always_comb begin
    if (i_smb_wr) begin
      wr_en   = 1'b1;
      wr_addr = i_smb_addr;
      wr_data = i_smb_wdata;
    end else begin
      wr_en   = i_otp_wr;
      wr_addr = i_otp_addr;
      wr_data = i_otp_wdata;
    end
  end

  // configuration registers keep their values across the external reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      dynamic_power_switch_cfg <= DPS_RESET;
    end else if (wr_en && wr_addr == DPS_ADDR) begin
      dynamic_power_switch_cfg <= wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      port_mode_cfg <= PORT_CFG_RESET;
    end else if (wr_en && wr_addr == PORT_CFG_ADDR) begin
      port_mode_cfg <= wr_data;
    end
  end

  // any value other than the enable code leaves switching off
  assign dynamic_on = (dynamic_power_switch_cfg == DPS_ENABLE);
  assign local_use  = port_mode_cfg[CFG_LOCAL_USE];

  // self-powered status: frozen capture, or live filtered detect when dynamic
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_self_powered <= 1'b0;
    end else if (run && dynamic_on) begin
      o_self_powered <= syn[SYN_LOCAL];
    end else if (run) begin
      o_self_powered <= supply_capture;
    end else begin
      o_self_powered <= 1'b0;
    end
  end

  // non-removable state: registers only when the shared pin is supply detect
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_port_fixed <= 2'b00;
    end else if (local_use) begin
      o_port_fixed <= port_mode_cfg[CFG_FIXED_LSB+1:CFG_FIXED_LSB];
    end else begin
      o_port_fixed <= fixed_strap;
    end
  end

  // charging is advertised only once running, and only where strapped on
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_port_charge_enable <= 2'b00;
    end else begin
      o_port_charge_enable <= run ? charge_strap : 2'b00;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_dynamic_power_active <= 1'b0;
      o_config_done          <= 1'b0;
    end else begin
      o_dynamic_power_active <= dynamic_on;
      o_config_done          <= run;
    end
  end

  // port 3 power and sense
  pps_port u_port3 (
    .i_clock         (i_clock),
    .i_rst_b         (i_rst_b),
    .i_run           (run),
    .i_combined      (port_mode_cfg[CFG_COMBINED_LSB]),
    .i_power_request (i_port_power_request[0]),
    .i_pin_sync      (syn[SYN_PIN3]),
    .i_sense_b_sync  (syn[SYN_SENSE3]),
    .o_pin           (o_port3_power_enable),
    .o_pin_oe        (o_port3_power_enable_oe),
    .o_power_on      (power_on[0]),
    .o_overcurrent   (overcurrent[0])
  );

  // port 4 power and sense
  pps_port u_port4 (
    .i_clock         (i_clock),
    .i_rst_b         (i_rst_b),
    .i_run           (run),
    .i_combined      (port_mode_cfg[CFG_COMBINED_LSB+1]),
    .i_power_request (i_port_power_request[1]),
    .i_pin_sync      (syn[SYN_PIN4]),
    .i_sense_b_sync  (syn[SYN_SENSE4]),
    .o_pin           (o_port4_power_enable),
    .o_pin_oe        (o_port4_power_enable_oe),
    .o_power_on      (power_on[1]),
    .o_overcurrent   (overcurrent[1])
  );

  assign o_port_overcurrent = overcurrent;

  // read-only status word
  always_comb begin
    status                                      = 8'h00;
    status[STS_SELF_POWERED]                    = o_self_powered;
    status[STS_DYNAMIC]                         = dynamic_on;
    status[STS_CONFIG_DONE]                     = run;
    status[STS_CHARGE_LSB+1:STS_CHARGE_LSB]     = charge_strap;
    status[STS_OVERCUR_LSB+1:STS_OVERCUR_LSB]   = overcurrent;
    status[7]                                   = |power_on;
  end

  // reads answer one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_smb_rdata  <= 8'h00;
      o_smb_rvalid <= 1'b0;
    end else begin
      o_smb_rvalid <= i_smb_rd;
      if (i_smb_rd) begin
        unique case (i_smb_addr)
          DPS_ADDR:      o_smb_rdata <= dynamic_power_switch_cfg;
          PORT_CFG_ADDR: o_smb_rdata <= port_mode_cfg;
          STATUS_ADDR:   o_smb_rdata <= status;
          default:       o_smb_rdata <= UNMAPPED_DATA;
        endcase
      end
    end
  end

endmodule

// ==== hw/pps_pkg.sv ====
// constants for downstream port power and strap capture, ports 3 and 4
// assumes a single 125 MHz clock and decoded SMBus/OTP byte writes
package pps_pkg;

  // register addresses
  localparam logic [15:0] DPS_ADDR       = 16'h4134;
  localparam logic [15:0] PORT_CFG_ADDR  = 16'h4135;
  localparam logic [15:0] STATUS_ADDR    = 16'h4136;

  // reset values and encodings
  localparam logic [7:0]  DPS_RESET      = 8'hc1;
  localparam logic [7:0]  DPS_ENABLE     = 8'h41;
  localparam logic [7:0]  PORT_CFG_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

  // port_mode_cfg field positions
  localparam int CFG_COMBINED_LSB = 0;   // bits 1:0, port 3 then port 4
  localparam int CFG_FIXED_LSB    = 2;   // bits 3:2, non-removable per port
  localparam int CFG_LOCAL_USE    = 4;   // local supply detect in use

  // port_power_status field positions
  localparam int STS_SELF_POWERED = 0;
  localparam int STS_DYNAMIC      = 1;
  localparam int STS_CONFIG_DONE  = 2;
  localparam int STS_CHARGE_LSB   = 3;   // bits 4:3
  localparam int STS_OVERCUR_LSB  = 5;   // bits 6:5

  // timing
  localparam int CLOCK_PERIOD_PS  = 8000;
  localparam int CONFIG_TIME_NS   = 1000;
  localparam int CONFIG_CYCLES    = (CONFIG_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int BLANK_TIME_NS    = 64;
  localparam int BLANK_CYCLES     = (BLANK_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // synchroniser lane order
  localparam int SYN_EXT_RESET = 0;
  localparam int SYN_LOCAL     = 1;
  localparam int SYN_PIN3      = 2;
  localparam int SYN_PIN4      = 3;
  localparam int SYN_SENSE3    = 4;
  localparam int SYN_SENSE4    = 5;
  localparam int SYN_FIXED_LSB = 6;     // lanes 7:6
  localparam int SYN_WIDTH     = 8;

  typedef enum logic [1:0] {
    PPS_STANDBY,
    PPS_CONFIG,
    PPS_RUN
  } pps_state_t;

endpackage

// ==== hw/pps_sync3.sv ====
// three-stage synchroniser with agreement filter for pin inputs
// assumes asynchronous inputs; output moves only when stages two and three agree
`timescale 1ns/1ps
module pps_sync3 #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  // asynchronous in, filtered out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only, never the filter
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per lane: accept a change once it has held two samples
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_sync <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          o_sync[i] <= stage2[i];
        end
      end
    end
  end

endmodule

// ==== hw/pps_port.sv ====
// one downstream port: power enable pin drive and over-current detection
// assumes synchronised pin and sense levels from the top level
`timescale 1ns/1ps
module pps_port
  import pps_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  // control from top
  input  wire logic i_run,
  input  wire logic i_combined,
  input  wire logic i_power_request,
  // synchronised pin levels
  input  wire logic i_pin_sync,
  input  wire logic i_sense_b_sync,
  // pin drive and status
  output logic      o_pin,
  output logic      o_pin_oe,
  output logic      o_power_on,
  output logic      o_overcurrent
);

  localparam logic [3:0] BLANK_LOAD = 4'(BLANK_CYCLES);

  logic       power_on;
  logic       next_power_on;
  logic [3:0] blank;
  logic       raw_fault;

  // an over-current latch removes power until the hub drops the request
  always_comb begin
    next_power_on = i_run && i_power_request && !o_overcurrent;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      power_on <= 1'b0;
    end else begin
      power_on <= next_power_on;
    end
  end

  // pin drive: released outside run so the strap can be read
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || !i_run) begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_combined) begin
      o_pin    <= 1'b0;
      o_pin_oe <= !next_power_on;
    end else begin
      o_pin    <= next_power_on;
      o_pin_oe <= 1'b1;
    end
  end

  // pull-up needs time to lift the pin after release; mask that window
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || !power_on) begin
      blank <= BLANK_LOAD;
    end else if (blank != 4'h0) begin
      blank <= blank - 4'h1;
    end
  end

  always_comb begin
    if (i_combined) begin
      raw_fault = !i_pin_sync;
    end else begin
      raw_fault = !i_sense_b_sync;
    end
  end

  // sticky fault, cleared when the request is withdrawn
  always_ff @(posedge i_clock) begin
    if (!i_rst_b || !i_run) begin
      o_overcurrent <= 1'b0;
    end else if (power_on && blank == 4'h0 && raw_fault) begin
      o_overcurrent <= 1'b1;
    end else if (!i_power_request) begin
      o_overcurrent <= 1'b0;
    end
  end

  assign o_power_on = power_on;

endmodule

// ==== dv/pps_checker_assertions.sv ====
// checker for port power control and strap capture, bound to pps_top
// assumes one clock domain and the synchronous active-low power-on reset
`timescale 1ns/1ps
module pps_checker
  import pps_pkg::*;
(
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  // watched inputs
  input wire logic [1:0]  i_port_power_request,
  input wire logic        i_local_supply_detect,
  input wire logic        i_smb_wr,
  input wire logic        i_smb_rd,
  input wire logic        i_otp_wr,
  input wire logic [15:0] i_smb_addr,
  input wire logic [7:0]  i_smb_wdata,
  // watched outputs
  input wire logic        o_port3_power_enable,
  input wire logic        o_port3_power_enable_oe,
  input wire logic        o_port4_power_enable,
  input wire logic        o_port4_power_enable_oe,
  input wire logic [1:0]  o_port_overcurrent,
  input wire logic        o_self_powered,
  input wire logic        o_dynamic_power_active,
  input wire logic        o_config_done,
  input wire logic        o_smb_rvalid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // enable byte written over smbus, then a quiet cycle so nothing overwrites it
  sequence dyn_write_s;
    i_smb_wr && i_smb_addr == DPS_ADDR && i_smb_wdata == DPS_ENABLE;
  endsequence
  sequence quiet_s;
    !i_smb_wr && !i_otp_wr;
  endsequence

  config_hold_a: assert property ($rose(i_rst_b) |-> (!o_config_done)[*8])
    else $error("run entered without a configuration window");
  pins_released_a: assert property ((!o_config_done)[*3] |->
    !o_port3_power_enable_oe && !o_port4_power_enable_oe)
    else $error("port pin driven outside run");
  power_cause_a: assert property (o_port3_power_enable && o_port3_power_enable_oe
    |-> $past(i_port_power_request[0]))
    else $error("port 3 powered without a request");
  dyn_set_a: assert property (dyn_write_s ##1 quiet_s |=> o_dynamic_power_active)
    else $error("dynamic switching not active after enable write");
  read_answer_a: assert property (o_smb_rvalid == $past(i_smb_rd))
    else $error("read valid not one cycle after read strobe");
  // the two extra past terms cover the cycle in which dynamic mode falls
  self_hold_a: assert property (o_config_done && $past(o_config_done)
    && !o_dynamic_power_active && !$past(o_dynamic_power_active)
    && !$past(o_dynamic_power_active, 2) |-> $stable(o_self_powered))
    else $error("captured self powered value moved");
  self_track_a: assert property ((o_config_done && o_dynamic_power_active
    && $stable(i_local_supply_detect))[*8] |-> o_self_powered == i_local_supply_detect)
    else $error("self powered does not follow supply detect");
  oc_cut_a: assert property ($rose(o_port_overcurrent[1]) |=> !o_port4_power_enable)
    else $error("port 4 still powered after overcurrent");
endmodule

bind pps_top pps_checker i_pps_checker (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_port_power_request(i_port_power_request),
  .i_local_supply_detect(i_local_supply_detect), .i_smb_wr(i_smb_wr), .i_smb_rd(i_smb_rd),
  .i_otp_wr(i_otp_wr), .i_smb_addr(i_smb_addr), .i_smb_wdata(i_smb_wdata),
  .o_port3_power_enable(o_port3_power_enable),
  .o_port3_power_enable_oe(o_port3_power_enable_oe),
  .o_port4_power_enable(o_port4_power_enable),
  .o_port4_power_enable_oe(o_port4_power_enable_oe),
  .o_port_overcurrent(o_port_overcurrent), .o_self_powered(o_self_powered),
  .o_dynamic_power_active(o_dynamic_power_active), .o_config_done(o_config_done),
  .o_smb_rvalid(o_smb_rvalid));

// ==== dv/pps_board.sv ====
// board model: power switches with fault injection and strap resistors
// assumes active-high switch enables that follow the hub drive level while it drives the shared pins
`timescale 1ns/1ps
module pps_board (
  // hub pin drive, bit0 port 3
  input  wire logic [1:0] i_out,
  input  wire logic [1:0] i_oe,
  // board setting from the bench
  input  wire logic [1:0] i_strap,
  input  wire logic [1:0] i_fault,
  // levels seen by the hub
  output logic      [1:0] o_pin,
  output logic      [1:0] o_sense_b
);
  logic [1:0] powered;

  // released pin shows the strap resistor, or the pull-up once running
  assign powered   = (i_oe & i_out) | (~i_oe & i_strap);
  // a faulting switch drags a released combined pin low
  assign o_pin     = (i_oe & i_out) | (~i_oe & i_strap & ~i_fault);
  // separate sense line is pulled up, low only on a powered fault
  assign o_sense_b = ~(i_fault & powered);
endmodule

// ==== dv/pps_top_tb.sv ====
// self-checking bench for pps_top with a board model on the port pins
// assumes a 125 MHz clock and the synchronous active-low power-on reset
`timescale 1ns/1ps
module pps_top_tb;
  import pps_pkg::*;
  logic        i_clock, i_rst_b, i_ext_reset_b, i_local_supply_detect, cap;
  logic        i_smb_wr, i_smb_rd, i_otp_wr, o_smb_rvalid;
  logic        o_self_powered, o_dynamic_power_active, o_config_done;
  logic [1:0]  i_fixed_port_straps, i_port_power_request, strap, fault, pin, sense_b;
  logic [1:0]  o_port_charge_enable, o_port_overcurrent, o_port_fixed, pout, poe;
  logic [15:0] i_smb_addr, i_otp_addr;
  logic [7:0]  i_smb_wdata, i_otp_wdata, o_smb_rdata;
  logic [31:0] r;
  integer      seed, n_errors, n_compared, i;

  pps_top i_pps_top (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_ext_reset_b(i_ext_reset_b),
    .i_port3_power_enable(pin[0]), .o_port3_power_enable(pout[0]),
    .o_port3_power_enable_oe(poe[0]), .i_port3_overcurrent_sense_b(sense_b[0]),
    .i_port4_power_enable(pin[1]), .o_port4_power_enable(pout[1]),
    .o_port4_power_enable_oe(poe[1]), .i_port4_overcurrent_sense_b(sense_b[1]),
    .i_local_supply_detect(i_local_supply_detect), .i_fixed_port_straps(i_fixed_port_straps),
    .i_port_power_request(i_port_power_request), .o_port_charge_enable(o_port_charge_enable),
    .o_port_overcurrent(o_port_overcurrent), .o_port_fixed(o_port_fixed),
    .o_self_powered(o_self_powered), .o_dynamic_power_active(o_dynamic_power_active),
    .o_config_done(o_config_done), .i_smb_wr(i_smb_wr), .i_smb_rd(i_smb_rd),
    .i_smb_addr(i_smb_addr), .i_smb_wdata(i_smb_wdata), .o_smb_rdata(o_smb_rdata),
    .o_smb_rvalid(o_smb_rvalid), .i_otp_wr(i_otp_wr), .i_otp_addr(i_otp_addr),
    .i_otp_wdata(i_otp_wdata));

  pps_board i_pps_board (.i_out(pout), .i_oe(poe), .i_strap(strap), .i_fault(fault),
    .o_pin(pin), .o_sense_b(sense_b));

  // expected {oe, out}: combined pins float high for power, push-pull always drives
  function automatic logic [1:0] exp_drive(input logic req, input logic comb);
    return comb ? (req ? 2'h0 : 2'h2) : {1'h1, req};
  endfunction
  function automatic logic exp_dyn(input logic [7:0] v);
    return v == DPS_ENABLE;
  endfunction

  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp, input string m);
    chk_reg({6'h0, got}, {6'h0, exp}, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic smb_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_smb_wr    <= 1'h1;
    i_smb_addr  <= a;
    i_smb_wdata <= d;
    @(posedge i_clock);
    i_smb_wr    <= 1'h0;
  endtask
  task automatic otp_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_otp_wr    <= 1'h1;
    i_otp_addr  <= a;
    i_otp_wdata <= d;
    @(posedge i_clock);
    i_otp_wr    <= 1'h0;
  endtask
  // answer stands one cycle after the strobe, so it is sampled just past that edge
  task automatic smb_read(input logic [15:0] a, input logic [7:0] exp, input string m);
    @(posedge i_clock);
    i_smb_rd   <= 1'h1;
    i_smb_addr <= a;
    @(posedge i_clock);
    i_smb_rd   <= 1'h0;
    #1;
    chk_pin({1'h0, o_smb_rvalid}, 2'h1, "read valid");
    chk_reg(o_smb_rdata, exp, m);
  endtask
  // bounded wait for run; the bound is well past the configuration window
  task automatic wait_config;
    for (i = 0; i < 300 && o_config_done !== 1'h1; i++) cyc(1);
    if (o_config_done !== 1'h1) begin
      n_errors++;
      $display("mismatch at %0t: configuration never ended", $time);
      stop_test();
    end
  endtask

  initial begin
    i_clock = 1'h0;
    forever #4 i_clock = ~i_clock;
  end

  initial begin
    seed = 90113;
    n_errors = 0;
    n_compared = 0;
    r = $random(seed);
    {i_smb_wr, i_smb_rd, i_otp_wr, i_rst_b, fault, i_port_power_request} = '0;
    {i_smb_addr, i_otp_addr, i_smb_wdata, i_otp_wdata} = '0;
    i_ext_reset_b = 1'h1;
    strap = r[1:0];
    i_local_supply_detect = r[2];
    i_fixed_port_straps = r[4:3];
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'h1;
    smb_read(DPS_ADDR, DPS_RESET, "dps reset");
    smb_read(PORT_CFG_ADDR, PORT_CFG_RESET, "cfg reset");
    smb_read(16'h4200, UNMAPPED_DATA, "unmapped read");
    wait_config();
    cap = i_local_supply_detect;
    chk_pin(o_port_charge_enable, strap, "charge straps");
    chk_pin({1'h0, o_self_powered}, {1'h0, cap}, "supply capture");
    chk_pin(o_port_fixed, i_fixed_port_straps, "fixed straps");
    $display("done: reset and capture");
    // released pins now see the pull-ups
    @(posedge i_clock);
    strap <= 2'h3;
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      @(posedge i_clock);
      i_port_power_request <= r[1:0];
      cyc(1);
      chk_pin({poe[0], pout[0]}, exp_drive(r[0], 1'h0), "port3 drive");
      chk_pin({poe[1], pout[1]}, exp_drive(r[1], 1'h0), "port4 drive");
    end
    @(posedge i_clock);
    i_local_supply_detect <= ~cap;
    cyc(12);
    chk_pin({1'h0, o_self_powered}, {1'h0, cap}, "static hold");
    smb_write(DPS_ADDR, DPS_ENABLE);
    cyc(12);
    chk_pin({1'h0, o_dynamic_power_active}, {1'h0, exp_dyn(DPS_ENABLE)}, "dyn on");
    chk_pin({1'h0, o_self_powered}, {1'h0, ~cap}, "dyn track");
    @(posedge i_clock);
    i_local_supply_detect <= cap;
    cyc(12);
    chk_pin({1'h0, o_self_powered}, {1'h0, cap}, "dyn track back");
    smb_write(DPS_ADDR, DPS_RESET);
    otp_write(DPS_ADDR, DPS_ENABLE);
    smb_read(DPS_ADDR, DPS_ENABLE, "otp load");
    otp_write(DPS_ADDR, DPS_RESET);
    cyc(3);
    chk_pin({1'h0, o_dynamic_power_active}, {1'h0, exp_dyn(DPS_RESET)}, "dyn off");
    $display("done: power and dynamic");
    // mode changes only with power requests low, so pins never glitch on
    @(posedge i_clock);
    i_port_power_request <= 2'h0;
    smb_write(PORT_CFG_ADDR, 8'h01);
    @(posedge i_clock);
    i_port_power_request <= 2'h3;
    cyc(1);
    chk_pin({poe[0], pout[0]}, exp_drive(1'h1, 1'h1), "combined on");
    cyc(20);
    @(posedge i_clock);
    fault <= 2'h3;
    for (i = 0; i < 50 && o_port_overcurrent !== 2'h3; i++) cyc(1);
    if (o_port_overcurrent !== 2'h3) begin
      n_errors++;
      $display("mismatch at %0t: overcurrent never latched", $time);
      stop_test();
    end
    cyc(2);
    chk_pin(o_port_overcurrent, 2'h3, "overcurrent");
    chk_pin({poe[0], pout[0]}, exp_drive(1'h0, 1'h1), "combined cut");
    chk_pin({poe[1], pout[1]}, exp_drive(1'h0, 1'h0), "push-pull cut");
    @(posedge i_clock);
    i_port_power_request <= 2'h0;
    fault <= 2'h0;
    cyc(4);
    chk_pin(o_port_overcurrent, 2'h0, "overcurrent clear");
    @(posedge i_clock);
    i_fixed_port_straps <= 2'h0;
    smb_write(PORT_CFG_ADDR, 8'h1c);
    cyc(6);
    chk_pin(o_port_fixed, 2'h3, "fixed from register");
    $display("done: combined and fixed");
    r = $random(seed);
    @(posedge i_clock);
    i_ext_reset_b <= 1'h0;
    strap <= r[1:0];
    i_local_supply_detect <= r[2];
    cyc(10);
    @(posedge i_clock);
    i_ext_reset_b <= 1'h1;
    cyc(2);
    wait_config();
    chk_pin(o_port_charge_enable, r[1:0], "recapture straps");
    chk_pin({1'h0, o_self_powered}, {1'h0, r[2]}, "recapture supply");
    smb_read(PORT_CFG_ADDR, 8'h1c, "cfg kept");
    smb_write(STATUS_ADDR, 8'hff);
    smb_read(STATUS_ADDR, {3'h0, r[1:0], 1'h1, 1'h0, r[2]}, "status");
    $display("done: external reset");
    stop_test();
  end
endmodule
